// *** pkg/tccf_map.vh ***
// register map, field positions and reset values of the timer flag block
`ifndef TCCF_MAP_VH
`define TCCF_MAP_VH

// register byte addresses
`define TCCF_ADDR_RUN_CTRL    8'h65
`define TCCF_ADDR_IRQ_ENABLE  8'h66
`define TCCF_ADDR_FLAG_STATUS 8'h67
`define TCCF_ADDR_COUNT       8'h68
`define TCCF_ADDR_GEN_A       8'h6A
`define TCCF_ADDR_GEN_B       8'h6C
`define TCCF_ADDR_CONTROL_ONE 8'h6E
`define TCCF_ADDR_IO_CTRL     8'h6F

// flag and enable bit positions
`define TCCF_BIT_MATCH_A 0
`define TCCF_BIT_MATCH_B 1
`define TCCF_BIT_WRAP    2

// run control bit positions
`define TCCF_BIT_RUN  0
`define TCCF_BIT_DOWN 1

// io control field positions
`define TCCF_IO_A_LSB 0
`define TCCF_IO_B_LSB 4

// reset values
`define TCCF_RST_COUNT    16'h0000
`define TCCF_RST_GEN      16'hFFFF
`define TCCF_RST_IO_CTRL  8'h88
`define TCCF_RST_CTRL_ONE 8'h80
`define TCCF_RST_RUN_CTRL 8'h00
`define TCCF_RST_ENABLE   3'h0

// fixed read-back bits, counter wrap limits and step
`define TCCF_RSVD_HI5 5'h1F
`define TCCF_COUNT_ALL_ONES 16'hFFFF
`define TCCF_COUNT_ZERO     16'h0000
`define TCCF_COUNT_STEP     16'h0001

`endif

// *** core/tccf_sync.v ***
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module tccf_sync (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// raw pin
	input wire pin,
	// edge pulses
	output wire rise,
	output wire fall
);

	reg meta_q; // first stage, read only by the second
	reg sync_q; // second stage, safe to use
	reg prev_q; // delayed copy for edge detection

	// synchroniser chain; the pin is asynchronous to clk
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edges seen only after both stages
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;

endmodule // tccf_sync

`default_nettype wire

// *** core/tccf_flag.v ***
// one status flag with read-then-write-zero clearing
`timescale 1ns/1ps
`default_nettype none

module tccf_flag (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// hardware event
	input wire set,
	// software access to the status register
	input wire rd,
	input wire wr,
	input wire wbit,
	// flag state
	output reg flag_q
);

	reg armed_q; // software has read this flag while it was 1

	// a write clears only after an earlier read saw the flag at 1
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			if (set) begin
				flag_q <= 1'b1; // set beats a same-cycle clear
			end else if (wr && !wbit && armed_q) begin
				flag_q <= 1'b0;
			end
			// writing 1 never changes the flag
			if (wr) begin
				armed_q <= 1'b0; // any write consumes the read
			end else if (rd && flag_q) begin
				armed_q <= 1'b1;
			end
		end
	end

endmodule // tccf_flag

`default_nettype wire

// *** core/tccf_top.v ***
// timer channel: counter, general registers, match and wrap flags
`timescale 1ns/1ps
`default_nettype none
`include "tccf_map.vh"

// Overview of operation
// - flag A set on compare match A
// - flag A set on capture into A
// - flag A cleared by read-one then write-zero
// - flag B set on compare match B
// - flag B set on capture into B
// - flag B cleared by read-one then write-zero
// - wrap flag set on counter wrap
// - wrap flag cleared by read then write-zero
// - writing one leaves flags unchanged
// - 16-bit read/write counter, zero after reset
// - io control picks compare or capture
// - register B captures on selected pin edges
// - wrap interrupt only while its enable set
module tccf_top (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// register port
	input wire [7:0] addr,
	input wire [15:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [15:0] rdata_q,
	// capture input pins
	input wire capture_a_pin,
	input wire capture_b_pin,
	// compare output pins
	output reg compare_a_out_q,
	output reg compare_b_out_q,
	// interrupts
	output reg irq_q,
	output reg wrap_irq_q
);

	////////////////////////////////////////////////////////////////
	// helper functions

	// capture edge select: 00 rising, 01 falling, 1x both
	function cap_hit;
		input [1:0] sel;
		input rise;
		input fall;
		begin
			case (sel)
				2'h0: cap_hit = rise;
				2'h1: cap_hit = fall;
				default: cap_hit = rise | fall;
			endcase
		end
	endfunction

	// compare pin action: 00 hold, 01 low, 10 high, 11 toggle
	function cmp_pin;
		input [1:0] sel;
		input cur;
		begin
			case (sel)
				2'h0: cmp_pin = cur;
				2'h1: cmp_pin = 1'b0;
				2'h2: cmp_pin = 1'b1;
				default: cmp_pin = ~cur;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// reset release

	reg rst_meta_q; // first reset stage
	reg rst_n_q; // released reset for all logic

	// assert at once, release after two edges
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// register state

	reg [15:0] count_value_q; // up/down counter
	reg [15:0] general_reg_a_q; // compare or capture A
	reg [15:0] general_reg_b_q; // compare or capture B
	reg [7:0] io_ctrl_q; // io select for A and B
	reg [7:0] ctrl_one_q; // control bits, stored only
	reg [7:0] run_ctrl_q; // run and direction
	reg [2:0] irq_enable_q; // interrupt mask, flag layout
	wire match_flag_a; // status bit 0
	wire match_flag_b; // status bit 1
	wire wrap_flag; // status bit 2

	// address decode
	wire wr_count = wr_en && (addr == `TCCF_ADDR_COUNT);
	wire wr_gen_a = wr_en && (addr == `TCCF_ADDR_GEN_A);
	wire wr_gen_b = wr_en && (addr == `TCCF_ADDR_GEN_B);
	wire wr_status = wr_en && (addr == `TCCF_ADDR_FLAG_STATUS);
	wire rd_status = rd_en && (addr == `TCCF_ADDR_FLAG_STATUS);

	// io select fields
	wire [2:0] io_a = io_ctrl_q[`TCCF_IO_A_LSB+2:`TCCF_IO_A_LSB];
	wire [2:0] io_b = io_ctrl_q[`TCCF_IO_B_LSB+2:`TCCF_IO_B_LSB];
	wire capture_mode_a = io_a[2]; // top bit set: capture
	wire capture_mode_b = io_b[2];

	////////////////////////////////////////////////////////////////
	// capture pins

	wire rise_a; // synchronised edge of pin A
	wire fall_a;
	wire rise_b; // synchronised edge of pin B
	wire fall_b;

	tccf_sync u_sync_a (
		.clk(mclk),
		.rst_n(rst_n_q),
		.pin(capture_a_pin),
		.rise(rise_a),
		.fall(fall_a)
	);

	tccf_sync u_sync_b (
		.clk(mclk),
		.rst_n(rst_n_q),
		.pin(capture_b_pin),
		.rise(rise_b),
		.fall(fall_b)
	);

	// capture strobes, only in capture mode
	wire capture_a = capture_mode_a && cap_hit(io_a[1:0], rise_a, fall_a);
	wire capture_b = capture_mode_b && cap_hit(io_b[1:0], rise_b, fall_b);

	////////////////////////////////////////////////////////////////
	// counter and events

	wire running = run_ctrl_q[`TCCF_BIT_RUN];
	wire count_down = run_ctrl_q[`TCCF_BIT_DOWN];
	// a software write to the counter wins over counting
	wire stepping = running && !wr_count;
	wire wrap_event = stepping && (count_down ?
		(count_value_q == `TCCF_COUNT_ZERO) :
		(count_value_q == `TCCF_COUNT_ALL_ONES));
	// matches stay quiet while the register is written
	wire match_a = !capture_mode_a && !wr_gen_a && (count_value_q == general_reg_a_q);
	wire match_b = !capture_mode_b && !wr_gen_b && (count_value_q == general_reg_b_q);
	wire set_a = match_a || capture_a;
	wire set_b = match_b || capture_b;

	// counter: written by software, else steps each clock when running
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			count_value_q <= `TCCF_RST_COUNT;
		end else if (wr_count) begin
			count_value_q <= wdata;
		end else if (stepping) begin
			if (count_down) begin
				count_value_q <= count_value_q - `TCCF_COUNT_STEP;
			end else begin
				count_value_q <= count_value_q + `TCCF_COUNT_STEP;
			end
		end
	end

	// general registers: capture beats a software write on the same edge
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			general_reg_a_q <= `TCCF_RST_GEN;
			general_reg_b_q <= `TCCF_RST_GEN;
		end else begin
			if (capture_a) begin
				general_reg_a_q <= count_value_q;
			end else if (wr_gen_a) begin
				general_reg_a_q <= wdata;
			end
			if (capture_b) begin
				general_reg_b_q <= count_value_q;
			end else if (wr_gen_b) begin
				general_reg_b_q <= wdata;
			end
		end
	end

	// control registers written by software
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			io_ctrl_q <= `TCCF_RST_IO_CTRL;
			ctrl_one_q <= `TCCF_RST_CTRL_ONE;
			run_ctrl_q <= `TCCF_RST_RUN_CTRL;
			irq_enable_q <= `TCCF_RST_ENABLE;
		end else if (wr_en) begin
			case (addr)
				`TCCF_ADDR_IO_CTRL: begin
					io_ctrl_q <= {1'b1, wdata[6:4], 1'b1, wdata[2:0]}; // reserved bits stay 1
				end
				`TCCF_ADDR_CONTROL_ONE: begin
					ctrl_one_q <= {1'b1, wdata[6:0]};
				end
				`TCCF_ADDR_RUN_CTRL: begin
					run_ctrl_q <= {6'h00, wdata[1:0]};
				end
				`TCCF_ADDR_IRQ_ENABLE: begin
					irq_enable_q <= wdata[2:0];
				end
				default: begin
					// other addresses leave control alone
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// status flags

	tccf_flag u_flag_a (
		.clk(mclk),
		.rst_n(rst_n_q),
		.set(set_a),
		.rd(rd_status),
		.wr(wr_status),
		.wbit(wdata[`TCCF_BIT_MATCH_A]),
		.flag_q(match_flag_a)
	);

	tccf_flag u_flag_b (
		.clk(mclk),
		.rst_n(rst_n_q),
		.set(set_b),
		.rd(rd_status),
		.wr(wr_status),
		.wbit(wdata[`TCCF_BIT_MATCH_B]),
		.flag_q(match_flag_b)
	);

	tccf_flag u_flag_wrap (
		.clk(mclk),
		.rst_n(rst_n_q),
		.set(wrap_event),
		.rd(rd_status),
		.wr(wr_status),
		.wbit(wdata[`TCCF_BIT_WRAP]),
		.flag_q(wrap_flag)
	);

	wire [2:0] flags = {wrap_flag, match_flag_b, match_flag_a};

	////////////////////////////////////////////////////////////////
	// compare pins

	// pin action taken on the same match that sets the flag
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			compare_a_out_q <= 1'b0;
			compare_b_out_q <= 1'b0;
		end else begin
			if (match_a) begin
				compare_a_out_q <= cmp_pin(io_a[1:0], compare_a_out_q);
			end
			if (match_b) begin
				compare_b_out_q <= cmp_pin(io_b[1:0], compare_b_out_q);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupts

	// registered, so they lag the flags by one clock
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_q <= 1'b0;
			wrap_irq_q <= 1'b0;
		end else begin
			irq_q <= |(flags & irq_enable_q);
			wrap_irq_q <= wrap_flag && irq_enable_q[`TCCF_BIT_WRAP];
		end
	end

	////////////////////////////////////////////////////////////////
	// read port

	// data valid the cycle after the strobe, zero otherwise
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 16'h0000;
		end else if (rd_en) begin
			case (addr)
				`TCCF_ADDR_COUNT: rdata_q <= count_value_q;
				`TCCF_ADDR_GEN_A: rdata_q <= general_reg_a_q;
				`TCCF_ADDR_GEN_B: rdata_q <= general_reg_b_q;
				`TCCF_ADDR_FLAG_STATUS: rdata_q <= {8'h00, `TCCF_RSVD_HI5, flags};
				`TCCF_ADDR_IRQ_ENABLE: rdata_q <= {8'h00, `TCCF_RSVD_HI5, irq_enable_q};
				`TCCF_ADDR_IO_CTRL: rdata_q <= {8'h00, io_ctrl_q};
				`TCCF_ADDR_CONTROL_ONE: rdata_q <= {8'h00, ctrl_one_q};
				`TCCF_ADDR_RUN_CTRL: rdata_q <= {8'h00, run_ctrl_q};
				default: rdata_q <= 16'h0000; // unmapped reads zero
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

endmodule // tccf_top

`default_nettype wire

// *** tb/tccf_monitor.sv ***
// assertion checker for the timer flag block
`timescale 1ns/1ps
`default_nettype none
`include "tccf_map.vh"

module tccf_monitor (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] rdata_q,
	// interrupts
	input wire logic irq_q,
	input wire logic wrap_irq_q
);

////////////////////////////////////////////////////////////////
logic [2:0] en_q; // mirror of enable bits
logic run_q; // mirror of run bit
logic down_q; // mirror of direction bit
wire logic st_rd = rd_en && addr == `TCCF_ADDR_FLAG_STATUS; // status read
wire logic cn_rd = rd_en && addr == `TCCF_ADDR_COUNT; // count read

// mirrors follow the writes so irq checks need no internal probes
always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		en_q <= 3'h0;
		run_q <= 1'b0;
		down_q <= 1'b0;
	end else if (wr_en && addr == `TCCF_ADDR_IRQ_ENABLE) begin
		en_q <= wdata[2:0];
	end else if (wr_en && addr == `TCCF_ADDR_RUN_CTRL) begin
		run_q <= wdata[0];
		down_q <= wdata[1];
	end
end

////////////////////////////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (!arst_n);

AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata_q == 16'h0000)
	else $error("read data not zero outside read slot");
AST_STAT_HI: assert property (st_rd |=> rdata_q[15:3] == 13'h001F)
	else $error("status upper bits wrong");
AST_WRAP_EN: assert property (wrap_irq_q |-> $past(en_q[2]))
	else $error("wrap irq while its enable clear");
AST_IRQ_EN: assert property (irq_q |-> $past(en_q) != 3'h0)
	else $error("irq while all enables clear");
AST_CNT_WR: assert property (wr_en && addr == `TCCF_ADDR_COUNT && !run_q ##1 cn_rd
	|=> rdata_q == $past(wdata, 2)) else $error("count write not read back");
AST_CNT_STEP: assert property (run_q && cn_rd ##1 cn_rd
	|=> rdata_q == $past(rdata_q) + (down_q ? 16'hFFFF : 16'h0001)) else $error("count step wrong");
AST_STICKY: assert property (st_rd ##1 st_rd
	|=> (rdata_q[2:0] & $past(rdata_q[2:0])) == $past(rdata_q[2:0])) else $error("flag lost without clear");
AST_W1_KEEP: assert property (st_rd ##1 (wr_en && addr == `TCCF_ADDR_FLAG_STATUS && wdata[2:0] == 3'h7)
	##1 st_rd |=> (rdata_q[2:0] & $past(rdata_q[2:0], 2)) == $past(rdata_q[2:0], 2))
	else $error("writing one cleared a flag");

// main scenarios reached
COV_WRAP: cover property (wrap_irq_q);
COV_IRQ: cover property (irq_q && !wrap_irq_q);
COV_CLR: cover property (st_rd ##1 wr_en && addr == `TCCF_ADDR_FLAG_STATUS && wdata[2:0] != 3'h7);

endmodule // tccf_monitor

bind tccf_top tccf_monitor u_mon (.mclk, .arst_n, .addr, .wdata, .wr_en, .rd_en, .rdata_q, .irq_q, .wrap_irq_q);
`default_nettype wire

// *** tb/tccf_top_tb.sv ***
// self-checking bench for the timer flag block
`timescale 1ns/1ps
`default_nettype none
`include "tccf_map.vh"

module tccf_top_tb;

////////////////////////////////////////////////////////////////
logic mclk = 1'b0; // 100 ns clock
logic arst_n = 1'b0; // held low at start
logic [7:0] addr = 8'h00;
logic [15:0] wdata = 16'h0000;
logic wr_en = 1'b0;
logic rd_en = 1'b0;
logic pa = 1'b0; // capture pin a
logic pb = 1'b0; // capture pin b
wire logic [15:0] rdata_q;
wire logic ca; // compare out a
wire logic cb; // compare out b
wire logic irq_q;
wire logic wrap_irq_q;
int n_mismatch = 0;
int check_count = 0;
localparam logic [7:0] a_run = `TCCF_ADDR_RUN_CTRL;
localparam logic [7:0] a_en = `TCCF_ADDR_IRQ_ENABLE;
localparam logic [7:0] a_st = `TCCF_ADDR_FLAG_STATUS;
localparam logic [7:0] a_cnt = `TCCF_ADDR_COUNT;
localparam logic [7:0] a_ga = `TCCF_ADDR_GEN_A;
localparam logic [7:0] a_gb = `TCCF_ADDR_GEN_B;
localparam logic [7:0] a_io = `TCCF_ADDR_IO_CTRL;

always #50 mclk = ~mclk;

tccf_top dut (
	.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata_q(rdata_q), .capture_a_pin(pa), .capture_b_pin(pb), .compare_a_out_q(ca),
	.compare_b_out_q(cb), .irq_q(irq_q), .wrap_irq_q(wrap_irq_q)
);

////////////////////////////////////////////////////////////////
// one bus slot: the next call replaces it, so strobes last one cycle
task op(input logic w, r, input logic [7:0] a, input logic [15:0] d);
	@(posedge mclk);
	wr_en <= w;
	rd_en <= r;
	addr <= a;
	wdata <= d;
endtask

task idle(input int n);
	repeat (n) op(1'b0, 1'b0, 8'h00, 16'h0000);
endtask

task chk(input string nm, input logic [15:0] e, s);
	check_count++;
	if (s !== e) begin
		$display("[FAIL] %s expected %h seen %h", nm, e, s);
		n_mismatch++;
	end
endtask

task wr(input logic [7:0] a, input logic [15:0] d);
	op(1'b1, 1'b0, a, d);
endtask

// data stand only in the cycle after the strobe
task rd(input logic [7:0] a, input logic [15:0] e);
	op(1'b0, 1'b1, a, 16'h0000);
	idle(1);
	#1;
	chk("rdata", e, rdata_q);
endtask

// irq outputs trail the register change by one cycle
task ichk(input logic i, w);
	idle(2);
	#1;
	chk("irq_q", 16'(i), 16'(irq_q));
	chk("wrap_irq_q", 16'(w), 16'(wrap_irq_q));
endtask

task test_done;
	$display("checks %0d mismatches %0d", check_count, n_mismatch);
	if (n_mismatch == 0 && check_count > 0) begin
		$display("No errors found");
	end else begin
		$display("Errors were found");
	end
	$finish;
endtask

////////////////////////////////////////////////////////////////
task t_reset;
	rd(a_cnt, 16'h0000);
	rd(a_ga, 16'hFFFF);
	rd(a_gb, 16'hFFFF);
	rd(a_io, 16'h0088);
	rd(8'h6E, 16'h0080);
	rd(a_en, 16'h00F8);
	rd(a_st, 16'h00F8);
	wr(8'h70, 16'h1234);
	rd(8'h70, 16'h0000);
	wr(a_cnt, 16'hA5C3);
	rd(a_cnt, 16'hA5C3);
	$display("reset test done");
endtask

task t_compare;
	wr(a_ga, 16'h0010);
	wr(a_gb, 16'h0020);
	wr(a_io, 16'h0032); // a drives high, b toggles
	wr(a_cnt, 16'h0000);
	wr(a_run, 16'h0001);
	idle(40);
	wr(a_run, 16'h0000);
	wr(a_cnt, 16'h0100); // park away from both matches
	rd(a_st, 16'h00FB);
	chk("compare_a", 16'h0001, 16'(ca));
	chk("compare_b", 16'h0001, 16'(cb));
	wr(a_en, 16'h0002);
	ichk(1'b1, 1'b0);
	wr(a_en, 16'h0000);
	ichk(1'b0, 1'b0);
	$display("compare test done");
endtask

task t_clear;
	wr(a_st, 16'h0007); // disarms, ones ignored
	wr(a_st, 16'h0000);
	rd(a_st, 16'h00FB);
	// read, write ones, read back to back: ones must not clear
	op(1'b0, 1'b1, a_st, 16'h0000);
	op(1'b1, 1'b0, a_st, 16'h0007);
	op(1'b0, 1'b1, a_st, 16'h0000);
	op(1'b0, 1'b1, a_st, 16'h0000);
	wr(a_st, 16'h0006);
	rd(a_st, 16'h00FA);
	wr(a_st, 16'h0000);
	rd(a_st, 16'h00F8);
	// parked count equal to register a: match holds every cycle
	wr(a_io, 16'h0031); // a drives low, b keeps toggle
	wr(a_ga, 16'h0100);
	idle(1);
	rd(a_st, 16'h00F9);
	chk("compare_a", 16'h0000, 16'(ca));
	wr(a_st, 16'h0000);
	rd(a_st, 16'h00F9);
	wr(a_ga, 16'h0010); // leave the match again
	wr(a_st, 16'h0000);
	rd(a_st, 16'h00F8);
	$display("clear test done");
endtask

task t_wrap;
	wr(a_en, 16'h0004);
	wr(a_cnt, 16'hFFFD);
	wr(a_run, 16'h0001);
	op(1'b0, 1'b1, a_cnt, 16'h0000);
	op(1'b0, 1'b1, a_cnt, 16'h0000);
	idle(4);
	wr(a_run, 16'h0000);
	rd(a_st, 16'h00FC);
	chk("wrap_irq_q", 16'h0001, 16'(wrap_irq_q));
	wr(a_st, 16'h0000);
	rd(a_st, 16'h00F8);
	ichk(1'b0, 1'b0);
	wr(a_cnt, 16'h0002);
	wr(a_run, 16'h0003); // count down
	idle(4);
	wr(a_run, 16'h0000);
	rd(a_st, 16'h00FC);
	wr(a_en, 16'h0000);
	ichk(1'b0, 1'b0);
	wr(a_st, 16'h0000);
	rd(a_st, 16'h00F8);
	$display("wrap test done");
endtask

task t_capture;
	wr(a_cnt, 16'h1234);
	wr(a_io, 16'h0045); // b rising, a falling
	@(posedge mclk);
	pb <= 1'b1;
	pa <= 1'b1;
	idle(5);
	rd(a_st, 16'h00FA);
	rd(a_gb, 16'h1234);
	@(posedge mclk);
	pa <= 1'b0;
	idle(5);
	rd(a_st, 16'h00FB);
	rd(a_ga, 16'h1234);
	wr(a_cnt, 16'h0055);
	wr(a_io, 16'h0065); // b on both edges
	@(posedge mclk);
	pb <= 1'b0;
	idle(5);
	rd(a_gb, 16'h0055);
	$display("capture test done");
endtask

////////////////////////////////////////////////////////////////
initial begin
	repeat (16) @(posedge mclk);
	arst_n <= 1'b1;
	idle(3);
	t_reset;
	t_compare;
	t_clear;
	t_wrap;
	t_capture;
	test_done;
end

// hang guard
initial begin
	#5000000;
	n_mismatch++;
	test_done;
end

endmodule // tccf_top_tb
`default_nettype wire
